// File: design/patwa_core.sv
// Paged effective address former and two's complement add datapath.
// Assumes one memory port that answers a read request with a valid pulse
// at least one cycle later; request and answer logic share clk.
// Bit numbering: documented bit n of a word is vector bit [11-n], so the
// sign (data bit 0) is [11] and the in-page offset is [6:0].
// A direct add raises done one cycle after the operand arrives; an
// indirect add first spends one memory read on the pointer word.
// An operate request raises done two cycles after it is taken.
// Requests are taken only while req_ready is high; others are dropped.
// A memory answer that arrives while no read is outstanding is ignored.
// The link is a separate bit: only the carry of an add flips it.
//
// Functional notes
// - Field is 4096 words, addresses 0..7777 octal.
// - 32 pages of 128 words each.
// - Instruction offset field is seven bits.
// - Bit 4 one selects current page.
// - Bit 4 zero selects page zero.
// - Offset taken from instruction bits 5..11.
// - Bit 3 zero: selected location is operand.
// - Bit 3 one: selected word is pointer.
// - Add is plain two's complement.
// - Carry out of sign toggles link.
// - Overflow keeps wrapped sum, no correction.
// - Data bit 0 is sign bit.
// - Invert plus increment negates accumulator.
// - Invert accumulator at first event time.
// - Increment accumulator at second event time.
`timescale 1ns/100ps
module patwa_core
    import patwa_pkg::*;
#(
    parameter int ADDR_W = WORD_W  // Field address width
)
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              req_valid,
    input  wire patwa_req_type     req,
    output logic                   req_ready,
    output patwa_mreq_type         mem_req,
    input  wire patwa_mrsp_type    mem_rsp,
    output logic [WORD_W-1:0]      accumulator,
    output logic                   link,
    output logic [WORD_W-1:0]      eff_addr,
    output logic                   done,
    output logic                   sign_neg
);
    // Only a 4096-word field of 12-bit words is served: the page split and
    // the pointer width both rely on it, so other geometries are refused
    if (ADDR_W != WORD_W || (1 << ADDR_W) != FIELD_WORDS
        || PAGE_COUNT * PAGE_WORDS != FIELD_WORDS
        || (1 << OFFSET_W) != PAGE_WORDS || PAGE_W + OFFSET_W != WORD_W)
    begin : g_bad_geometry
        $error("patwa_core: unsupported field geometry");
    end

    // Sequencer state, the request held while it is served, datapath nets
    patwa_state_type   state;
    patwa_req_type     cur;
    logic [WORD_W-1:0] direct_addr;
    logic [PAGE_W-1:0] page_sel;
    logic [WORD_W:0]   add_sum;
    logic [WORD_W-1:0] opr_stage1;
    logic [WORD_W-1:0] inc_step;

    // Page select: own page bits or page zero, offset from bits 5..11
    always_comb
    begin
        page_sel = req.insn[INSN_CURPAGE_POS] ?
                   req.insn_pc[WORD_W-1 -: PAGE_W] : PAGE_ZERO;
        direct_addr = {page_sel, req.insn[OFFSET_W-1:0]};
    end

    // Add with one extra bit to catch the carry out of the sign position
    assign add_sum = {1'b0, accumulator} + {1'b0, mem_rsp.data};

    // Event time 1: invert when the operate word asks for it
    assign opr_stage1 = (cur.insn[OPR_INVERT_POS] ? ~accumulator : accumulator);

    // Event time 2: the step that the increment bit adds on top
    assign inc_step = cur.insn[OPR_INC_POS] ? WORD_ONE : WORD_ZERO;

    // Ready is a flip-flop so that no output leaves through logic; it drops
    // on the taking edge and rises as the sequencer falls back to idle
    always_ff @(posedge clk)
    begin
        if (srst)
            req_ready <= 1'b1;
        else if (state == PATWA_IDLE && req_valid
                 && (req.op == PATWA_OP_ADD || req.op == PATWA_OP_OPR))
            req_ready <= 1'b0;
        else if (!(state inside {PATWA_IDLE, PATWA_PTR, PATWA_OPND, PATWA_EVENT2}))
            req_ready <= 1'b1;  // Done or a stray code: idle follows next
    end

    // Sequencer: address forming, optional pointer fetch, operand fetch
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state    <= PATWA_IDLE;
            cur      <= '0;
            mem_req  <= '0;
            eff_addr <= WORD_ZERO;
            done     <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state)
                // Take an add or operate request; an add reads at once
                PATWA_IDLE:
                begin
                    if (req_valid && req.op == PATWA_OP_ADD)
                    begin
                        cur           <= req;
                        mem_req.valid <= 1'b1;
                        mem_req.addr  <= direct_addr;
                        if (req.insn[INSN_INDIRECT_POS])
                            state <= PATWA_PTR;
                        else
                        begin
                            eff_addr <= direct_addr;
                            state    <= PATWA_OPND;
                        end
                    end
                    else if (req_valid && req.op == PATWA_OP_OPR)
                    begin
                        cur   <= req;
                        state <= PATWA_EVENT2;
                    end
                end
                // Pointer read outstanding: its answer is the operand address
                PATWA_PTR:
                begin
                    mem_req.valid <= 1'b0;
                    if (mem_rsp.valid)
                    begin
                        // Pointer word is a full absolute address in the field
                        eff_addr      <= mem_rsp.data;
                        mem_req.valid <= 1'b1;
                        mem_req.addr  <= mem_rsp.data;
                        state         <= PATWA_OPND;
                    end
                end
                // Operand read outstanding: done follows its answer
                PATWA_OPND:
                begin
                    mem_req.valid <= 1'b0;
                    if (mem_rsp.valid)
                    begin
                        done  <= 1'b1;
                        state <= PATWA_DONE;
                    end
                end
                // Operate: the accumulator block does both event times here
                PATWA_EVENT2:
                begin
                    done  <= 1'b1;
                    state <= PATWA_DONE;
                end
                // One spare cycle so done never meets the next take
                PATWA_DONE:
                    state <= PATWA_IDLE;
                default:
                    state <= PATWA_IDLE;
            endcase
        end
    end

    // Accumulator updates
    always_ff @(posedge clk)
    begin
        if (srst)
            accumulator <= WORD_ZERO;
        else if (state == PATWA_OPND && mem_rsp.valid)
        begin
            // Wrapped sum kept as is: on overflow the sign may be wrong but
            // the low eleven bits are right, and no correction is tried
            accumulator <= add_sum[WORD_W-1:0];
        end
        else if (state == PATWA_EVENT2)
        begin
            // Increment follows invert, so both bits together negate; doing
            // the two event times in one cycle saves a state per operate
            accumulator <= opr_stage1 + inc_step;
        end
    end

    // Link: a carry out of the sign position flips it; it is never set
    // outright, and the carry is never fed back into the low bit
    always_ff @(posedge clk)
    begin
        if (srst)
            link <= 1'b0;
        else if (state == PATWA_OPND && mem_rsp.valid)
            link <= link ^ add_sum[WORD_W];
    end

    // Sign of an operate result; worked out from the same inputs as the
    // accumulator so the flag never lags the value by a cycle
    function automatic logic next_sign(input logic [WORD_W-1:0] v,
                                       input logic [WORD_W-1:0] step);
        logic [WORD_W-1:0] r;
        r = v + step;
        return r[SIGN_POS];
    endfunction : next_sign

    // Sign flag mirrors data bit 0 of the accumulator
    always_ff @(posedge clk)
    begin
        if (srst)
            sign_neg <= 1'b0;
        else if (state == PATWA_OPND && mem_rsp.valid)
            sign_neg <= add_sum[SIGN_POS];
        else if (state == PATWA_EVENT2)
            sign_neg <= next_sign(opr_stage1, inc_step);
    end
endmodule : patwa_core

// File: design/patwa_pkg.sv
// Package for the paged address and two's complement add datapath slice.
// Assumes a 12-bit word machine with bit 0 as the most significant bit.
package patwa_pkg;
    localparam int WORD_W      = 12;     // Word, accumulator and address width
    localparam int OFFSET_W    = 7;      // In-page offset width
    localparam int PAGE_W      = 5;      // Page number width
    localparam int FIELD_WORDS = 4096;   // Words in one memory field
    localparam int PAGE_WORDS  = 128;    // Words in one page
    localparam int PAGE_COUNT  = 32;     // Pages in one field
    // Instruction bit positions, big-endian numbering: bit n is [11-n]
    localparam int INSN_INDIRECT_POS = 8;  // Instruction bit 3
    localparam int INSN_CURPAGE_POS  = 7;  // Instruction bit 4
    localparam int SIGN_POS          = 11; // Data bit 0
    localparam int OPR_INVERT_POS    = 5;  // Operate word, octal 0040
    localparam int OPR_INC_POS       = 0;  // Operate word, octal 0001
    localparam logic [WORD_W-1:0]   WORD_ZERO  = 12'h000;
    localparam logic [WORD_W-1:0]   WORD_ONE   = 12'h001;
    localparam logic [PAGE_W-1:0]   PAGE_ZERO  = 5'h00;
    localparam logic [WORD_W-1:0]   INVERT_CODE = 12'he20;  // Octal 7040
    localparam logic [WORD_W-1:0]   INC_CODE    = 12'he01;  // Octal 7001

    // Operation request from the instruction context
    typedef enum logic [1:0]
    {
        PATWA_OP_NONE = 2'h0,
        PATWA_OP_ADD  = 2'h1,  // twos_add_to_accumulator
        PATWA_OP_OPR  = 2'h3   // Group 1 operate (invert / increment)
    } patwa_op_type;

    typedef struct packed
    {
        logic [WORD_W-1:0] insn;     // Instruction word
        logic [WORD_W-1:0] insn_pc;  // Address of the instruction
        patwa_op_type      op;
    } patwa_req_type;

    // Memory read request / answer
    typedef struct packed
    {
        logic              valid;
        logic [WORD_W-1:0] addr;
    } patwa_mreq_type;

    typedef struct packed
    {
        logic              valid;
        logic [WORD_W-1:0] data;
    } patwa_mrsp_type;

    typedef enum logic [2:0]
    {
        PATWA_IDLE    = 3'h0,
        PATWA_PTR     = 3'h1,
        PATWA_OPND    = 3'h3,
        PATWA_EVENT2  = 3'h2,
        PATWA_DONE    = 3'h6
    } patwa_state_type;
endpackage : patwa_pkg

// File: sim/patwa_core_assertions.sv
// Checker for the paged address and add datapath slice.
// Assumes it is bound to patwa_core and sees only its ports.
`timescale 1ns/100ps
module patwa_core_assertions
    import patwa_pkg::*;
(
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              req_valid,
    input wire patwa_req_type     req,
    input wire logic              req_ready,
    input wire patwa_mreq_type    mem_req,
    input wire patwa_mrsp_type    mem_rsp,
    input wire logic [WORD_W-1:0] accumulator,
    input wire logic              link,
    input wire logic [WORD_W-1:0] eff_addr,
    input wire logic              done,
    input wire logic              sign_neg
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Accepted requests by kind
    wire add = req_valid && req_ready && (req.op == PATWA_OP_ADD);
    wire opr = req_valid && req_ready && (req.op == PATWA_OP_OPR);
    // Sum with carry of what the accumulator and the memory show right now
    wire [WORD_W:0] sum_now = {1'b0, accumulator} + {1'b0, mem_rsp.data};
    // High from an indirect take until the pointer word comes back, so the
    // operand answer that follows is never taken for the pointer
    logic ptr_wait;
    always_ff @(posedge clk)
        if (srst)
            ptr_wait <= 1'b0;
        else if (add && req.insn[8])
            ptr_wait <= 1'b1;
        else if (mem_rsp.valid)
            ptr_wait <= 1'b0;
    a_page_zero: assert property (add && !req.insn[7] |=> mem_req.valid
        && mem_req.addr == {PAGE_ZERO, $past(req.insn[6:0])}) else $error("page zero");
    a_cur_page: assert property (add && req.insn[7] |=> mem_req.valid
        && mem_req.addr == {$past(req.insn_pc[11:7]), $past(req.insn[6:0])}) else $error("page");
    a_direct_ea: assert property (add && !req.insn[8]
        |=> eff_addr == mem_req.addr) else $error("ea");
    a_ptr_follow: assert property (ptr_wait && mem_rsp.valid |=> mem_req.valid
        && mem_req.addr == $past(mem_rsp.data) && eff_addr == $past(mem_rsp.data))
        else $error("pointer");
    a_add_sum: assert property (mem_rsp.valid ##1 done
        |-> accumulator == $past(accumulator) + $past(mem_rsp.data)) else $error("sum");
    a_link_toggle: assert property (mem_rsp.valid ##1 done
        |-> link == ($past(link) ^ $past(sum_now[WORD_W]))) else $error("link");
    a_negate_acc: assert property (opr && req.insn[5] && req.insn[0]
        |-> ##2 done && accumulator == -$past(accumulator, 2)) else $error("negate");
    a_invert_only: assert property (opr && req.insn[5] && !req.insn[0]
        |-> ##2 done && accumulator == ~$past(accumulator, 2)) else $error("invert");
    a_inc_only: assert property (opr && !req.insn[5] && req.insn[0]
        |-> ##2 done && accumulator == $past(accumulator, 2) + WORD_ONE) else $error("increment");
    a_sign_copy: assert property (sign_neg == accumulator[SIGN_POS]) else $error("sign");
endmodule : patwa_core_assertions
bind patwa_core patwa_core_assertions patwa_core_assertions_inst (.clk, .srst, .req_valid,
    .req, .req_ready, .mem_req, .mem_rsp, .accumulator, .link, .eff_addr, .done, .sign_neg);

// File: sim/patwa_core_test.sv
// Self-checking bench for the paged address and add datapath slice.
// Assumes the memory model answers each read after lat cycles.
`timescale 1ns/100ps
module patwa_core_test import patwa_pkg::*;;
    logic              clk = 1'b0, srst = 1'b1, req_valid = 1'b0, exp_link = 1'b0;
    logic              req_ready, link, done, sign_neg;
    patwa_req_type     req = '0;
    logic [3:0]        lat = 4'h1;
    patwa_mreq_type    mem_req;
    patwa_mrsp_type    mem_rsp;
    logic [WORD_W-1:0] accumulator, eff_addr, exp_acc = 12'h000;
    int                miscompares = 0, check_count = 0;
    always #2 clk = ~clk;
    patwa_core patwa_core_inst (.clk, .srst, .req_valid, .req, .req_ready, .mem_req,
        .mem_rsp, .accumulator, .link, .eff_addr, .done, .sign_neg);
    patwa_mem_model patwa_mem_model_inst (.clk, .mem_req, .lat, .mem_rsp);
    task check(input logic [12:0] seen, input logic [12:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    // One request held over its taking edge, then a bounded wait for done
    task issue(input logic [11:0] insn, input logic [11:0] pc, input patwa_op_type op);
        int i;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{insn, pc, op};
        @(posedge clk);
        req_valid <= 1'b0;
        for (i = 0; i < 40 && done !== 1'b1; i++)
            @(posedge clk);
        if (i == 40)
        begin
            miscompares++;
            finish_test();
        end
        @(posedge clk);
    endtask : issue
    // Mirror of the memory model's contents, one word per address
    function automatic logic [11:0] mem_word(input logic [11:0] a);
        return {a[4:0], a[11:5]} ^ 12'h3c5;
    endfunction : mem_word
    // Add with the expected address and sum worked out here
    task run_add(input logic [11:0] insn, input logic [11:0] pc);
        logic [11:0] ea;
        logic [12:0] sum;
        ea = insn[7] ? {pc[11:7], insn[6:0]} : {5'h00, insn[6:0]};
        if (insn[8])
            ea = mem_word(ea);
        sum = {1'b0, exp_acc} + {1'b0, mem_word(ea)};
        exp_acc = sum[11:0];
        exp_link ^= sum[12];
        issue(insn, pc, PATWA_OP_ADD);
        check({1'b0, eff_addr}, {1'b0, ea});
        check({link, accumulator}, {exp_link, exp_acc});
    endtask : run_add
    task run_opr(input logic [11:0] insn);
        if (insn[5])
            exp_acc = ~exp_acc;
        if (insn[0])
            exp_acc = exp_acc + WORD_ONE;
        issue(insn, 12'h000, PATWA_OP_OPR);
        check({sign_neg, accumulator}, {exp_acc[11], exp_acc});
    endtask : run_opr
    // Page zero against current page, top of field and page boundary
    task t_paging;
        check({req_ready, accumulator}, 13'h1000);
        run_add(12'h045, 12'ha80);
        run_add(12'h0c5, 12'ha80);
        run_add(12'h0ff, 12'hfff);
        $display("paging done");
    endtask : t_paging
    // A request that names no operation is dropped: nothing moves
    task t_refuse;
        int i;
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= '{INVERT_CODE | INC_CODE, 12'h000, PATWA_OP_NONE};
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            check({done | mem_req.valid, accumulator}, {1'b0, exp_acc});
        end
        req_valid <= 1'b0;
        check({req_ready, accumulator}, {1'b1, exp_acc});
        $display("refuse done");
    endtask : t_refuse
    // Pointers read with a slow memory
    task t_indirect;
        lat <= 4'h5;
        run_add(12'h17f, 12'h300);
        run_add(12'h1a0, 12'h300);
        lat <= 4'h1;
        $display("indirect done");
    endtask : t_indirect
    // Each operate form, then subtract by negate and add, with carries
    task t_arith;
        run_opr(INVERT_CODE);
        run_opr(INC_CODE);
        run_opr(INVERT_CODE | INC_CODE);
        run_add(12'h01f, 12'h000);
        repeat (4) run_add(12'h0bf, 12'h780);
        $display("arith done");
    endtask : t_arith
    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_paging();
        t_refuse();
        t_indirect();
        t_arith();
        finish_test();
    end
endmodule : patwa_core_test

// File: sim/patwa_mem_model.sv
// Memory field model answering reads after a chosen latency.
// Assumes one outstanding read; data wobbles while no answer stands.
`timescale 1ns/100ps
module patwa_mem_model
    import patwa_pkg::*;
(
    input  wire logic           clk,
    input  wire patwa_mreq_type mem_req,
    input  wire logic [3:0]     lat,
    output patwa_mrsp_type      mem_rsp
);
    logic [WORD_W-1:0] addr  = 12'h000;
    logic [WORD_W-1:0] last  = 12'h000;
    logic [3:0]        count = 4'h0;
    // Content of any of the 4096 words, reachable by a 12-bit address
    function automatic logic [WORD_W-1:0] word(input logic [WORD_W-1:0] a);
        return {a[4:0], a[11:5]} ^ 12'h3c5;
    endfunction : word
    // Latch the read and count down to the answer
    always_ff @(posedge clk)
        if (mem_req.valid)
            {addr, count} <= {mem_req.addr, lat};
        else if (count != 4'h0)
            count <= count - 4'h1;
    // Inverse of the last value so a stale bus never looks valid
    always_ff @(posedge clk)
        last <= mem_rsp.data;
    assign mem_rsp.valid = (count == 4'h1);
    assign mem_rsp.data  = mem_rsp.valid ? word(addr) : ~last;
endmodule : patwa_mem_model
